/* rtl/ivm_top.sv */
// interrupt vector map: source flags, enables and requests per vector
// assumes peripheral events are one-cycle hclk pulses, bus is AHB-Lite
//
// What this block does
// [RL1] a source event sets its flag whatever the enable holds
// [RL2] each source except the nmi has a software written enable bit
// [RL3] a request needs both flag and enable set
// [RL4] a maskable request holds until software clears its flag, its enable or the global enable, the nmi request until its flag
// [RL5] maskable requests also need the global enable
// [RL6] every assigned vector number belongs to exactly one source
// [RL7] vector 1 is the scan checksum nmi, 0 is reset entry
// [RL8] vector 2 supply monitor, 3 to 5 port pin changes
// [RL9] vector 6 rtc count, 7 periodic tick
// [RL10] vectors 8 to 12 timer a overflow, high underflow, compares
// [RL11] vector 13 timer b
// [RL12] vector 17 comparator, 20 and 21 converter
// [RL13] vectors 24 and 25 two wire, 26 serial peripheral
// [RL14] vectors 27 to 29 serial port, 30 nvm ready
// [RL15] unassigned vectors never request and read as zero
`timescale 1ns/1ps
module ivm_top
   import ivm_pkg::*;
#(
   parameter int unsigned NUM_VEC = IVM_NUM_VEC
) (
   input wire logic hclk, // system clock
   input wire logic hresetn, // async reset, active low
   input wire logic ce, // clock enable, freezes state
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // word only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic hresp, // response
   output logic [31:0] hrdata, // read data
   input wire logic [NUM_VEC-1:0] src_event, // per vector condition pulses
   output logic [NUM_VEC-1:0] irq_req, // per vector requests
   output logic nmi_req, // non-maskable request
   output logic irq_any, // any request active
   output logic irq_vec_valid, // irq_vec holds a request
   output logic [4:0] irq_vec // lowest pending vector
);

   ivm_reg_if rb ();

   logic [31:0] flag_r;
   logic [31:0] flag_nxt;
   logic [31:0] en_r;
   logic [31:0] ovr_r;
   logic [31:0] ovr_nxt;
   logic [31:0] req_r;
   logic [31:0] req_nxt;
   logic gie_r;
   logic pend_valid_r;
   logic [4:0] pend_vec_r;
   logic pend_valid;
   logic [4:0] pend_vec;
   logic [31:0] hw_set;
   logic [31:0] sw_set;
   logic [31:0] flag_clr;
   logic [31:0] ovr_clr;
   logic [31:0] en_eff;
   logic [31:0] rdata;
   logic unused_size;

   // strobe and address passed in so continuous assigns see them change
   function automatic logic wr_hit(input logic wr, input logic [7:0] a, input logic [7:0] ofs);
      return wr && (a == ofs);
   endfunction

   function automatic logic [31:0] widen(input logic [NUM_VEC-1:0] v);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[NUM_VEC-1:0] = v;
      return w;
   endfunction

   assign unused_size = ^hsize;

   ivm_ahb_front u_front (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .rb(rb)
   );

   // [RL1] events set flags, enable not consulted
   assign hw_set = widen(src_event) & VEC_MAP;
   assign sw_set = wr_hit(rb.wr, rb.addr, OFS_FLAG_SET) ? (rb.wdata & VEC_MAP) : 32'h0000_0000;
   assign flag_clr = wr_hit(rb.wr, rb.addr, OFS_FLAG) ? rb.wdata : 32'h0000_0000;
   assign ovr_clr = wr_hit(rb.wr, rb.addr, OFS_OVR) ? rb.wdata : 32'h0000_0000;

   // [RL4] flag holds until write-one clear, set wins
   assign flag_nxt = ((flag_r & ~flag_clr) | hw_set | sw_set) & VEC_MAP;

   // overrun: event hit an already pending flag
   assign ovr_nxt = ((ovr_r & ~ovr_clr) | (hw_set & flag_r)) & VEC_MAP;

   // [RL7] nmi enable reads as always on
   assign en_eff = en_r | NMI_MASK;

   // [RL3] [RL5] [RL7] flag and enable, global gate except nmi
   assign req_nxt = (flag_r & en_eff & ~NMI_MASK & {32{gie_r}})
      | (flag_r & NMI_MASK);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_r <= RST_FLAG;
      end else if (ce) begin
         flag_r <= flag_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovr_r <= RST_OVR;
      end else if (ce) begin
         ovr_r <= ovr_nxt;
      end
   end

   // [RL2] software switches sources on or off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_r <= RST_ENABLE;
      end else if (ce && wr_hit(rb.wr, rb.addr, OFS_ENABLE)) begin
         en_r <= rb.wdata & VEC_MAP & ~NMI_MASK;
      end
   end

   // [RL5] global enable bit
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gie_r <= RST_GIE;
      end else if (ce && wr_hit(rb.wr, rb.addr, OFS_GCTRL)) begin
         gie_r <= rb.wdata[GCTRL_GIE_BIT];
      end
   end

   // [RL15] unmapped vectors masked off
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_r <= RST_REQ;
      end else if (ce) begin
         req_r <= req_nxt & VEC_MAP;
      end
   end

   ivm_prio_enc #(
      .NUM_VEC(NUM_VEC)
   ) u_prio (
      .req(req_nxt[NUM_VEC-1:0] & VEC_MAP[NUM_VEC-1:0]),
      .valid(pend_valid),
      .vec(pend_vec)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pend_valid_r <= 1'b0;
         pend_vec_r <= 5'h00;
      end else if (ce) begin
         pend_valid_r <= pend_valid;
         pend_vec_r <= pend_vec;
      end
   end

   // [RL6] bit index is vector number
   assign irq_req = req_r[NUM_VEC-1:0];
   assign nmi_req = |(req_r & NMI_MASK);
   assign irq_any = pend_valid_r;
   assign irq_vec_valid = pend_valid_r;
   assign irq_vec = pend_vec_r;

   // register read mux, unmapped reads zero
   always_comb begin
      rdata = 32'h0000_0000;
      case (rb.addr)
         OFS_FLAG: rdata = flag_r;
         OFS_ENABLE: rdata = en_eff & VEC_MAP;
         OFS_GCTRL: rdata[GCTRL_GIE_BIT] = gie_r;
         OFS_REQ: rdata = req_r;
         OFS_PEND: begin
            rdata[PEND_VALID_BIT] = pend_valid_r;
            rdata[4:0] = pend_vec_r;
         end
         OFS_OVR: rdata = ovr_r;
         OFS_MAP: rdata = VEC_MAP;
         default: rdata = 32'h0000_0000;
      endcase
   end

   assign rb.rdata = rdata;

endmodule

/* rtl/ivm_pkg.sv */
// constants, register map and vector map of the interrupt vector block
// assumes one 200 MHz clock and a 32-bit AHB-Lite register bus
package ivm_pkg;

   localparam int unsigned IVM_NUM_VEC = 31;

   // vector numbers toward the cpu core
   localparam logic [4:0] VEC_RESET_ENTRY = 5'h00;
   localparam logic [4:0] VEC_SCAN_CHECKSUM_NMI = 5'h01;
   localparam logic [4:0] VEC_SUPPLY_LEVEL_MONITOR = 5'h02;
   localparam logic [4:0] VEC_PORT_A_PIN_CHANGE = 5'h03;
   localparam logic [4:0] VEC_PORT_B_PIN_CHANGE = 5'h04;
   localparam logic [4:0] VEC_PORT_C_PIN_CHANGE = 5'h05;
   localparam logic [4:0] VEC_RTC_COUNT = 5'h06;
   localparam logic [4:0] VEC_PERIODIC_TICK = 5'h07;
   localparam logic [4:0] VEC_TIMER_A_OVERFLOW = 5'h08;
   localparam logic [4:0] VEC_TIMER_A_HIGH_UNDERFLOW = 5'h09;
   localparam logic [4:0] VEC_TIMER_A_COMPARE0 = 5'h0A;
   localparam logic [4:0] VEC_TIMER_A_COMPARE1 = 5'h0B;
   localparam logic [4:0] VEC_TIMER_A_COMPARE2 = 5'h0C;
   localparam logic [4:0] VEC_TIMER_B = 5'h0D;
   localparam logic [4:0] VEC_COMPARATOR = 5'h11;
   localparam logic [4:0] VEC_CONVERTER_RESULT_READY = 5'h14;
   localparam logic [4:0] VEC_CONVERTER_WINDOW = 5'h15;
   localparam logic [4:0] VEC_TWO_WIRE_TARGET = 5'h18;
   localparam logic [4:0] VEC_TWO_WIRE_CONTROLLER = 5'h19;
   localparam logic [4:0] VEC_SERIAL_PERIPH = 5'h1A;
   localparam logic [4:0] VEC_SERIAL_RX_COMPLETE = 5'h1B;
   localparam logic [4:0] VEC_SERIAL_TX_EMPTY = 5'h1C;
   localparam logic [4:0] VEC_SERIAL_TX_COMPLETE = 5'h1D;
   localparam logic [4:0] VEC_NVM_READY = 5'h1E;

   // register byte offsets
   localparam logic [7:0] OFS_FLAG = 8'h00;
   localparam logic [7:0] OFS_FLAG_SET = 8'h04;
   localparam logic [7:0] OFS_ENABLE = 8'h08;
   localparam logic [7:0] OFS_GCTRL = 8'h0C;
   localparam logic [7:0] OFS_REQ = 8'h10;
   localparam logic [7:0] OFS_PEND = 8'h14;
   localparam logic [7:0] OFS_OVR = 8'h18;
   localparam logic [7:0] OFS_MAP = 8'h1C;

   // field positions and reset values
   localparam int unsigned GCTRL_GIE_BIT = 0;
   localparam int unsigned PEND_VALID_BIT = 5;
   localparam logic [31:0] RST_FLAG = 32'h0000_0000;
   localparam logic [31:0] RST_ENABLE = 32'h0000_0000;
   localparam logic RST_GIE = 1'b0;
   localparam logic [31:0] RST_REQ = 32'h0000_0000;
   localparam logic [31:0] RST_OVR = 32'h0000_0000;
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;

   typedef enum logic [1:0] {
      IVM_ST_IDLE = 2'b00,
      IVM_ST_WR = 2'b01,
      IVM_ST_RD = 2'b10,
      IVM_ST_RDY = 2'b11
   } ivm_state_e;

   function automatic logic [31:0] ivm_vbit(input logic [4:0] v);
      return 32'h0000_0001 << v;
   endfunction

   // [RL6] one bit per vector
   localparam logic [31:0] NMI_MASK = ivm_vbit(VEC_SCAN_CHECKSUM_NMI);
   // [RL7] [RL8] nmi, monitor and port vectors
   localparam logic [31:0] MAP_LOW = NMI_MASK | ivm_vbit(VEC_SUPPLY_LEVEL_MONITOR)
      | ivm_vbit(VEC_PORT_A_PIN_CHANGE) | ivm_vbit(VEC_PORT_B_PIN_CHANGE)
      | ivm_vbit(VEC_PORT_C_PIN_CHANGE);
   // [RL9] [RL10] [RL11] counter and timer vectors
   localparam logic [31:0] MAP_TMR = ivm_vbit(VEC_RTC_COUNT) | ivm_vbit(VEC_PERIODIC_TICK)
      | ivm_vbit(VEC_TIMER_A_OVERFLOW) | ivm_vbit(VEC_TIMER_A_HIGH_UNDERFLOW)
      | ivm_vbit(VEC_TIMER_A_COMPARE0) | ivm_vbit(VEC_TIMER_A_COMPARE1)
      | ivm_vbit(VEC_TIMER_A_COMPARE2) | ivm_vbit(VEC_TIMER_B);
   // [RL12] [RL13] [RL14] analog, serial and nvm vectors
   localparam logic [31:0] MAP_HIGH = ivm_vbit(VEC_COMPARATOR)
      | ivm_vbit(VEC_CONVERTER_RESULT_READY) | ivm_vbit(VEC_CONVERTER_WINDOW)
      | ivm_vbit(VEC_TWO_WIRE_TARGET) | ivm_vbit(VEC_TWO_WIRE_CONTROLLER)
      | ivm_vbit(VEC_SERIAL_PERIPH) | ivm_vbit(VEC_SERIAL_RX_COMPLETE)
      | ivm_vbit(VEC_SERIAL_TX_EMPTY) | ivm_vbit(VEC_SERIAL_TX_COMPLETE)
      | ivm_vbit(VEC_NVM_READY);
   // [RL15] unlisted vectors stay out
   localparam logic [31:0] VEC_MAP = MAP_LOW | MAP_TMR | MAP_HIGH;

endpackage

/* rtl/ivm_reg_if.sv */
// register access strobes between bus front end and register file
// assumes both ends run on hclk
`timescale 1ns/1ps
interface ivm_reg_if;
   logic wr;
   logic rd;
   logic [7:0] addr;
   logic [31:0] wdata;
   logic [31:0] rdata;
   modport front (output wr, output rd, output addr, output wdata, input rdata);
   modport regs (input wr, input rd, input addr, input wdata, output rdata);
endinterface

/* rtl/ivm_ahb_front.sv */
// AHB-Lite slave front end: single word transfers, reads take one wait
// assumes it is the only slave, so hready equals its own hreadyout
`timescale 1ns/1ps
module ivm_ahb_front
   import ivm_pkg::*;
(
   input wire logic hclk, // system clock
   input wire logic hresetn, // async reset, active low
   input wire logic ce, // clock enable
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // slave ready
   output logic hresp, // always okay
   output logic [31:0] hrdata, // read data
   ivm_reg_if.front rb // register strobes
);

   ivm_state_e st_r;
   ivm_state_e st_nxt;
   logic [7:0] addr_r;
   logic [31:0] hrdata_r;
   logic accept;

   assign accept = hsel & htrans[1] & hready & ce;
   // waits while frozen and in the first read cycle
   assign hreadyout = ce & (st_r != IVM_ST_RD);
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;
   assign rb.addr = addr_r;
   assign rb.wdata = hwdata;
   assign rb.wr = ce & (st_r == IVM_ST_WR);
   assign rb.rd = ce & (st_r == IVM_ST_RD);

   always_comb begin
      st_nxt = st_r;
      case (st_r)
         IVM_ST_RD: begin
            st_nxt = IVM_ST_RDY;
         end
         IVM_ST_IDLE, IVM_ST_WR, IVM_ST_RDY: begin
            if (accept) begin
               st_nxt = hwrite ? IVM_ST_WR : IVM_ST_RD;
            end else begin
               st_nxt = IVM_ST_IDLE;
            end
         end
         default: begin
            st_nxt = IVM_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= IVM_ST_IDLE;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_r <= 8'h00;
      end else if (accept) begin
         addr_r <= haddr[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= RST_RDATA;
      end else if (rb.rd) begin
         hrdata_r <= rb.rdata;
      end
   end

endmodule

/* rtl/ivm_prio_enc.sv */
// picks the lowest numbered active request
// assumes bit index equals vector number
`timescale 1ns/1ps
module ivm_prio_enc #(
   parameter int unsigned NUM_VEC = 31
) (
   input wire logic [NUM_VEC-1:0] req, // active requests
   output logic valid, // any request active
   output logic [4:0] vec // winning vector number
);

   always_comb begin
      valid = 1'b0;
      vec = 5'h00;
      for (int i = NUM_VEC - 1; i >= 0; i--) begin
         if (req[i]) begin
            valid = 1'b1;
            vec = 5'(i);
         end
      end
   end

endmodule

/* sim/ivm_cpu_model.sv */
// cpu core stand-in: fetches the offered vector every cycle
// assumes irq_vec outputs are registered on the same clock
`timescale 1ns/1ps
module ivm_cpu_model (
   input wire logic clk, // system clock
   input wire logic rst_n, // async reset, active low
   input wire logic irq_vec_valid, // vector offered
   input wire logic [4:0] irq_vec, // offered vector
   output logic [4:0] taken_vec // last vector fetched
);
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         taken_vec <= 5'h00;
      end else if (irq_vec_valid) begin
         taken_vec <= irq_vec;
      end
   end
endmodule

/* sim/ivm_top_chk.sv */
// port checker for the vector map top
// bound to every ivm_top instance
`timescale 1ns/1ps
module ivm_top_chk
   import ivm_pkg::*;
#(
   parameter int unsigned NUM_VEC = IVM_NUM_VEC
) (
   input wire logic hclk, // clock
   input wire logic hresetn, // reset, active low
   input wire logic ce, // clock enable
   input wire logic hsel, // select
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write
   input wire logic hready, // bus ready
   input wire logic hreadyout, // slave ready
   input wire logic [NUM_VEC-1:0] src_event, // events
   input wire logic [NUM_VEC-1:0] irq_req, // requests
   input wire logic nmi_req, // nmi
   input wire logic irq_any, // any request
   input wire logic irq_vec_valid, // vector valid
   input wire logic [4:0] irq_vec // vector
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   logic wr_req;
   logic rd_req;
   assign wr_req = hsel && htrans[1] && hready && ce && hwrite;
   assign rd_req = hsel && htrans[1] && hready && ce && !hwrite;
   chk_unmapped_quiet: assert property ((irq_req & ~VEC_MAP[NUM_VEC-1:0]) == '0)
      else $error("unassigned vector requested");
   chk_nmi_is_vec1: assert property (nmi_req == irq_req[1])
      else $error("nmi differs from vector 1");
   chk_nmi_event: assert property (ce && src_event[1] ##1 ce |=> nmi_req)
      else $error("nmi not raised two cycles after event");
   chk_req_holds: assert property (|($past(irq_req) & ~irq_req) |-> $past(wr_req, 3))
      else $error("request dropped without a write");
   chk_vec_lowest: assert property (irq_vec_valid |-> irq_req[irq_vec]
      && (irq_req & ((NUM_VEC'(1) << irq_vec) - NUM_VEC'(1))) == '0)
      else $error("vector is not the lowest request");
   chk_any_valid: assert property (irq_any == irq_vec_valid && irq_vec_valid == (|irq_req))
      else $error("any or valid disagrees with requests");
   chk_read_wait: assert property (rd_req |=> !hreadyout)
      else $error("read data phase without wait");
   chk_freeze_hold: assert property (!ce |-> !hreadyout ##1 irq_req == $past(irq_req))
      else $error("state moved while clock enable low");
endmodule
bind ivm_top ivm_top_chk #(.NUM_VEC(NUM_VEC)) u_chk (.hclk(hclk), .hresetn(hresetn),
   .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .src_event(src_event), .irq_req(irq_req), .nmi_req(nmi_req),
   .irq_any(irq_any), .irq_vec_valid(irq_vec_valid), .irq_vec(irq_vec));

/* sim/test_ivm_top.sv */
// bench for the vector map: AHB-Lite register tasks and event pulses
// assumes hready is the slave's own hreadyout
`timescale 1ns/1ps
module test_ivm_top;
   import ivm_pkg::*;
   localparam logic [31:0] EXP_MAP = 32'h7F32_3FFE;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic ce = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [30:0] src_event = '0;
   logic hreadyout, hresp, nmi_req, irq_any, irq_vec_valid;
   logic [31:0] hrdata, d;
   logic [30:0] irq_req;
   logic [4:0] irq_vec, taken_vec;
   int err_count = 0;
   int checks = 0;
   int cyc = 0;
   always #2.5 hclk = ~hclk;
   ivm_top DUT (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .src_event(src_event),
      .irq_req(irq_req), .nmi_req(nmi_req), .irq_any(irq_any),
      .irq_vec_valid(irq_vec_valid), .irq_vec(irq_vec));
   ivm_cpu_model cpu (.clk(hclk), .rst_n(hresetn), .irq_vec_valid(irq_vec_valid),
      .irq_vec(irq_vec), .taken_vec(taken_vec));
   task end_sim;
      if (err_count == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         end_sim;
      end
   end
   task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task w(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      d = hrdata;
   endtask
   task ev(input logic [30:0] m);
      src_event <= m;
      @(posedge hclk);
      src_event <= '0;
      w(3);
   endtask
   initial begin
      w(16);
      hresetn <= 1'b1;
      w(1);
      xfer(0, 8'h08, 0); cmp("enable", 32'h0000_0002, d);
      cmp("hresp", 32'h0000_0000, {31'h0, hresp});
      xfer(0, 8'h0C, 0); cmp("gctrl", 32'h0000_0000, d);
      xfer(0, 8'h1C, 0); cmp("map", EXP_MAP, d);
      xfer(0, 8'h40, 0); cmp("unmapped", 32'h0000_0000, d);
      ev('1);
      xfer(0, 8'h00, 0); cmp("flag", EXP_MAP, d);
      cmp("irq_req masked", 32'h0000_0002, {1'b0, irq_req});
      xfer(1, 8'h08, 32'hFFFF_FFFF);
      xfer(0, 8'h08, 0); cmp("enable", EXP_MAP, d);
      cmp("irq_req no gie", 32'h0000_0002, {1'b0, irq_req});
      xfer(1, 8'h0C, 32'h0000_0001);
      w(3);
      cmp("irq_req gie", EXP_MAP, {1'b0, irq_req});
      cmp("irq_any", 32'h0000_0001, {31'h0, irq_any});
      xfer(0, 8'h14, 0); cmp("pend", 32'h0000_0021, d);
      for (int v = 1; v < 31; v++) begin
         if (EXP_MAP[v]) begin
            cmp("irq_vec", v, {27'h0, irq_vec});
            cmp("taken_vec", v, {27'h0, taken_vec});
            xfer(1, 8'h00, 32'h0000_0001 << v);
            w(3);
         end
      end
      cmp("irq_req cleared", 32'h0000_0000, {1'b0, irq_req});
      ev(31'h0000_0040);
      w(20);
      cmp("irq_req held", 32'h0000_0040, {1'b0, irq_req});
      xfer(1, 8'h08, EXP_MAP & ~32'h0000_0040);
      w(2);
      cmp("irq_req off", 32'h0000_0000, {1'b0, irq_req});
      xfer(0, 8'h00, 0); cmp("flag kept", 32'h0000_0040, d);
      xfer(1, 8'h08, EXP_MAP);
      ce <= 1'b0;
      w(10);
      cmp("irq_req frozen", 32'h0000_0000, {1'b0, irq_req});
      ce <= 1'b1;
      w(3);
      cmp("irq_req on", 32'h0000_0040, {1'b0, irq_req});
      xfer(1, 8'h0C, 32'h0000_0000);
      w(2);
      cmp("irq_req gie off", 32'h0000_0000, {1'b0, irq_req});
      ev(31'h0000_0002);
      cmp("nmi", 32'h0000_0001, {31'h0, nmi_req});
      xfer(1, 8'h00, 32'h0000_0042);
      w(2);
      cmp("nmi cleared", 32'h0000_0000, {31'h0, nmi_req});
      xfer(1, 8'h04, 32'hFFFF_FFFF);
      xfer(0, 8'h00, 0); cmp("flag set", EXP_MAP, d);
      ev(31'h0000_0004);
      xfer(0, 8'h18, 0); cmp("overrun", 32'h0000_0004, d);
      xfer(0, 8'h10, 0); cmp("req reg", 32'h0000_0002, d);
      xfer(1, 8'h18, 32'h0000_0004);
      xfer(0, 8'h18, 0); cmp("overrun cleared", 32'h0000_0000, d);
      xfer(1, 8'h00, 32'hFFFF_FFFF);
      w(2);
      cmp("irq_req all clear", 32'h0000_0000, {1'b0, irq_req});
      end_sim;
   end
endmodule
